// file: verilog/acrm_pkg.sv
// Shared constants, types and helpers of the converter configuration bank
package acrm_pkg;
  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [12:0] A_SETUP  = 13'h0000;
  localparam logic [12:0] A_ID     = 13'h0001;
  localparam logic [12:0] A_GRADE  = 13'h0002;
  localparam logic [12:0] A_POWER  = 13'h0008;
  localparam logic [12:0] A_CLOCK  = 13'h0009;
  localparam logic [12:0] A_TEST   = 13'h000D;
  localparam logic [12:0] A_STEST  = 13'h000E;
  localparam logic [12:0] A_OMODE  = 13'h0014;
  localparam logic [12:0] A_DITHER = 13'h0030;
  localparam logic [12:0] A_COMMIT = 13'h00FF;

  // ------------------------------------------------------------
  // Reset values and writable bits
  // ------------------------------------------------------------
  localparam logic [7:0] R_SETUP  = 8'h18;
  localparam logic [7:0] R_POWER  = 8'h80;
  localparam logic [7:0] R_CLOCK  = 8'h01;
  localparam logic [7:0] R_TEST   = 8'h00;
  localparam logic [7:0] R_STEST  = 8'h04;
  localparam logic [7:0] R_OMODE  = 8'h00;
  localparam logic [7:0] R_DITHER = 8'h00;
  localparam logic [7:0] R_COMMIT = 8'h00;
  localparam logic [7:0] M_LSB    = 8'h42;
  localparam logic [7:0] M_POWER  = 8'h23;
  localparam logic [7:0] M_CLOCK  = 8'h01;
  localparam logic [7:0] M_TEST   = 8'h37;
  localparam logic [7:0] M_STEST  = 8'h05;
  localparam logic [7:0] M_OMODE  = 8'h50;
  localparam logic [7:0] M_DITHER = 8'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int P_LSB_HI    = 6;
  localparam int P_LSB_LO    = 1;
  localparam int P_SRST_HI   = 5;
  localparam int P_SRST_LO   = 2;
  localparam int P_GRADE_LO  = 4;
  localparam int P_PIN_STBY  = 5;
  localparam int P_DUTY_STAB = 0;
  localparam int P_RST_LONG  = 5;
  localparam int P_RST_SHORT = 4;
  localparam int P_ST_EN     = 0;
  localparam int P_ST_RESTART = 2;
  localparam int P_OM_TYPE   = 6;
  localparam int P_OM_OFF    = 4;
  localparam int P_DITH_EN   = 4;
  localparam int P_XFER      = 0;
  localparam int P_READ      = 15;
  // Synchroniser lanes
  localparam int I_PDN  = 0;
  localparam int I_OE   = 1;
  localparam int I_DITH = 2;
  localparam int I_TYPE = 3;
  localparam int I_WR   = 4;

  // ------------------------------------------------------------
  // Frame timing in link clock edges
  // ------------------------------------------------------------
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST  = 5'h17;
  localparam logic [4:0] FRAME_END  = 5'h18;

  // ------------------------------------------------------------
  // Patterns and generator seeds
  // ------------------------------------------------------------
  localparam logic [13:0] PAT_MID   = 14'h2000;
  localparam logic [13:0] PAT_POS   = 14'h3FFF;
  localparam logic [13:0] PAT_NEG   = 14'h0000;
  localparam logic [13:0] PAT_CHK_A = 14'h2AAA;
  localparam logic [13:0] PAT_CHK_B = 14'h1555;
  localparam logic [22:0] SEED_LONG  = 23'h7FFFFF;
  localparam logic [8:0]  SEED_SHORT = 9'h1FF;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TST_OFF, TST_MID, TST_POS_FULL, TST_NEG_FULL,
    TST_CHECKER, TST_LONG_PN, TST_SHORT_PN, TST_ONE_ZERO
  } acrm_test_t;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_FULL_DOWN, PWR_STANDBY} acrm_power_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } acrm_wr_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] id;
    logic [7:0] grade;
    logic [7:0] power;
    logic [7:0] clock;
    logic [7:0] test;
    logic [7:0] stest;
    logic [7:0] omode;
    logic [7:0] dither;
    logic [7:0] commit;
  } acrm_view_t;

  // Readback byte for an address; open locations read zero
  function automatic logic [7:0] acrm_read_byte(acrm_view_t v, logic [12:0] a);
    case (a)
      A_SETUP:  return v.setup;
      A_ID:     return v.id;
      A_GRADE:  return v.grade;
      A_POWER:  return v.power;
      A_CLOCK:  return v.clock;
      A_TEST:   return v.test;
      A_STEST:  return v.stest;
      A_OMODE:  return v.omode;
      A_DITHER: return v.dither;
      A_COMMIT: return v.commit;
      default:  return 8'h00;
    endcase
  endfunction

  // Write strobe for one address
  function automatic logic acrm_hit(acrm_wr_t w, logic ev, logic [12:0] a);
    return ev && (w.addr == a);
  endfunction
endpackage

// file: verilog/acrm_serial_port.sv
// Serial port front end running on the link clock
`timescale 1ns/1ns
`default_nettype none
module acrm_serial_port (
  // Link pins
  input  wire logic                 sclk,
  input  wire logic                 csb_n,
  input  wire logic                 sdio_in,
  output var  logic                 sdio_out,
  output var  logic                 sdio_oe,
  // Core side
  input  wire logic                 rst_n,
  input  wire acrm_pkg::acrm_view_t view,
  input  wire logic                 view_tog,
  output var  acrm_pkg::acrm_wr_t   wr_req,
  output var  logic                 wr_tog
);
  logic [4:0]           cnt_q;
  logic [14:0]          shin_q;
  logic [12:0]          addr_q;
  logic                 read_q;
  logic [7:0]           out_q;
  logic [2:0]           vsync_q;
  logic                 vseen_q;
  acrm_pkg::acrm_view_t view_q;
  logic                 lsb_first;
  logic [15:0]          word16;
  logic [7:0]           word8;
  logic [7:0]           seq;

  // ------------------------------------------------------------
  // Bit order decode
  // ------------------------------------------------------------
  assign lsb_first = view_q.setup[acrm_pkg::P_LSB_HI];

  always_comb begin
    word16 = {shin_q, sdio_in};
    word8  = {shin_q[6:0], sdio_in};
    if (lsb_first) begin
      word16 = {<<{shin_q, sdio_in}};
      word8  = {<<{shin_q[6:0], sdio_in}};
    end
    seq = acrm_pkg::acrm_read_byte(view_q, word16[12:0]);
    if (lsb_first) begin
      seq = {<<{seq}};
    end
  end

  // ------------------------------------------------------------
  // Frame sequencing, ends with chip select
  // ------------------------------------------------------------
  always_ff @(posedge sclk or posedge csb_n) begin
    if (csb_n) begin
      cnt_q    <= 5'h00;
      shin_q   <= 15'h0000;
      addr_q   <= 13'h0000;
      read_q   <= 1'b0;
      out_q    <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else begin
      shin_q <= {shin_q[13:0], sdio_in};
      if (cnt_q != acrm_pkg::FRAME_END) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (cnt_q == acrm_pkg::INSTR_LAST) begin
        addr_q <= word16[12:0];
        read_q <= word16[acrm_pkg::P_READ];
        if (word16[acrm_pkg::P_READ]) begin
          sdio_oe  <= 1'b1;
          sdio_out <= seq[7];
          out_q    <= {seq[6:0], 1'b0};
        end
      end else if (read_q && cnt_q < acrm_pkg::DATA_LAST) begin
        sdio_out <= out_q[7];
        out_q    <= {out_q[6:0], 1'b0};
      end else if (cnt_q == acrm_pkg::DATA_LAST) begin
        sdio_oe <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Write hand-off to the core, held until the next write
  // ------------------------------------------------------------
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_req <= '0;
      wr_tog <= 1'b0;
    end else if (cnt_q == acrm_pkg::DATA_LAST && !read_q) begin
      wr_req <= '{addr: addr_q, data: word8};
      wr_tog <= ~wr_tog;
    end
  end

  // ------------------------------------------------------------
  // Readback view capture
  // ------------------------------------------------------------
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      vsync_q <= 3'h0;
      vseen_q <= 1'b0;
      view_q  <= '0;
    end else begin
      vsync_q <= {vsync_q[1:0], view_tog};
      if (vsync_q[1] == vsync_q[2] && vsync_q[2] != vseen_q) begin
        vseen_q <= vsync_q[2];
        view_q  <= view;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/acrm_register_bank.sv
// Configuration register bank of the converter with pattern and self-test logic
// How it works
// - Setup register mirrors bit order and soft reset; bits 4,3 one; resets 0x18.
// - Mirrored nibbles decode a setup write in either shift order.
// - Only listed locations act; others read zero and ignore writes.
// - Power field: 00 and 11 normal, 01 full power-down, 10 standby.
// - Test field: off, midscale, positive, negative full scale, checkerboard.
// - Codes 101..111 give long, short sequence, one/zero word; bits 5,4 reset generators.
// - Shadowed registers act only after writing 0x01 to 0xFF; bit self-clears.
// - Power-down, output disable, dither, output type are OR of bit and pin.
`timescale 1ns/1ns
`default_nettype none
module acrm_register_bank #(
  parameter logic [7:0] PART_IDENTIFIER     = 8'h3C,
  parameter logic [1:0] SPEED_GRADE = 2'h1
) (
  // Core clock
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // Serial port
  input  wire logic                  sclk,
  input  wire logic                  csb_n,
  input  wire logic                  sdio_in,
  output var  logic                  sdio_out,
  output var  logic                  sdio_oe,
  // Control pins
  input  wire logic                  power_down_pin,
  input  wire logic                  output_enable_pin,
  input  wire logic                  dither_pin,
  input  wire logic                  output_type_pin,
  // Converter data
  input  wire logic [13:0]           adc_data,
  output var  logic [13:0]           data_out,
  // Effective controls
  output var  acrm_pkg::acrm_power_t power_mode,
  output var  logic                  duty_cycle_stabilizer,
  output var  logic                  outputs_disabled,
  output var  logic                  dither_enable,
  output var  logic                  lvds_output,
  // Self test
  output var  logic                  built_in_self_test_active,
  output var  logic [15:0]           built_in_self_test_signature
);
  // PART_IDENTIFIER default is an arbitrary value

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  acrm_pkg::acrm_wr_t   wr;
  logic                 wr_tog;
  logic [4:0]           raw;
  logic [4:0]           s1_q;
  logic [4:0]           s2_q;
  logic [4:0]           s3_q;
  logic [4:0]           filt_q;
  logic [4:0]           same;
  logic                 wr_event;
  logic                 soft_rst;
  logic                 lsb_q;
  logic [7:0]           pwr_m_q;
  logic [7:0]           clk_m_q;
  logic [7:0]           tst_m_q;
  logic [7:0]           st_m_q;
  logic [7:0]           om_m_q;
  logic [7:0]           dth_m_q;
  logic [7:0]           pwr_a_q;
  logic [7:0]           clk_a_q;
  logic [7:0]           tst_a_q;
  logic [7:0]           st_a_q;
  logic [7:0]           om_a_q;
  logic                 xfer_q;
  logic [22:0]          long_seq_q;
  logic [8:0]           short_seq_q;
  logic                 alt_q;
  logic                 built_in_self_test_start;
  logic                 built_in_self_test_restart;
  acrm_pkg::acrm_test_t test_mode;
  acrm_pkg::acrm_view_t live;
  acrm_pkg::acrm_view_t view_q;
  logic                 view_tog_q;

  // ------------------------------------------------------------
  // Serial front end
  // ------------------------------------------------------------
  acrm_serial_port u_port (
    .sclk     (sclk),
    .csb_n    (csb_n),
    .sdio_in  (sdio_in),
    .sdio_out (sdio_out),
    .sdio_oe  (sdio_oe),
    .rst_n    (rst_n),
    .view     (view_q),
    .view_tog (view_tog_q),
    .wr_req   (wr),
    .wr_tog   (wr_tog)
  );

  // ------------------------------------------------------------
  // Input synchronisers with agreement filter
  // ------------------------------------------------------------
  assign raw  = {wr_tog, output_type_pin, dither_pin, output_enable_pin, power_down_pin};
  assign same = ~(s2_q ^ s3_q);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q   <= 5'h00;
      s2_q   <= 5'h00;
      s3_q   <= 5'h00;
      filt_q <= 5'h00;
    end else if (ce) begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s3_q & same) | (filt_q & ~same);
    end
  end

  assign wr_event = same[acrm_pkg::I_WR] & (s3_q[acrm_pkg::I_WR] ^ filt_q[acrm_pkg::I_WR]);

  assign soft_rst = acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_SETUP)
                  & (wr.data[acrm_pkg::P_SRST_HI] | wr.data[acrm_pkg::P_SRST_LO]);

  // ------------------------------------------------------------
  // Master registers as written by the host
  // ------------------------------------------------------------
  // Only listed bits stored
  always_ff @(posedge clock) begin
    if (!rst_n || (ce && soft_rst)) begin
      lsb_q   <= 1'b0;
      pwr_m_q <= acrm_pkg::R_POWER;
      clk_m_q <= acrm_pkg::R_CLOCK;
      tst_m_q <= acrm_pkg::R_TEST;
      st_m_q  <= acrm_pkg::R_STEST;
      om_m_q  <= acrm_pkg::R_OMODE;
      dth_m_q <= acrm_pkg::R_DITHER;
    end else if (ce) begin
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_SETUP)) begin
        lsb_q <= wr.data[acrm_pkg::P_LSB_HI] | wr.data[acrm_pkg::P_LSB_LO];
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_POWER)) begin
        pwr_m_q <= (wr.data & acrm_pkg::M_POWER) | acrm_pkg::R_POWER;
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_CLOCK)) begin
        clk_m_q <= wr.data & acrm_pkg::M_CLOCK;
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_TEST)) begin
        tst_m_q <= wr.data & acrm_pkg::M_TEST;
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_STEST)) begin
        st_m_q <= wr.data & acrm_pkg::M_STEST;
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_OMODE)) begin
        om_m_q <= wr.data & acrm_pkg::M_OMODE;
      end
      if (acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_DITHER)) begin
        dth_m_q <= wr.data & acrm_pkg::M_DITHER;
      end
    end
  end

  // ------------------------------------------------------------
  // Commit strobe
  // ------------------------------------------------------------
  // Transfer bit self-clears
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xfer_q <= 1'b0;
    end else if (ce) begin
      xfer_q <= acrm_pkg::acrm_hit(wr, wr_event, acrm_pkg::A_COMMIT)
              & wr.data[acrm_pkg::P_XFER];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || (ce && soft_rst)) begin
      pwr_a_q <= acrm_pkg::R_POWER;
      clk_a_q <= acrm_pkg::R_CLOCK;
      tst_a_q <= acrm_pkg::R_TEST;
      st_a_q  <= acrm_pkg::R_STEST;
      om_a_q  <= acrm_pkg::R_OMODE;
    end else if (ce && xfer_q) begin
      pwr_a_q <= pwr_m_q;
      clk_a_q <= clk_m_q;
      tst_a_q <= tst_m_q;
      st_a_q  <= st_m_q;
      om_a_q  <= om_m_q;
    end
  end

  // ------------------------------------------------------------
  // Effective controls
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_mode            <= acrm_pkg::PWR_NORMAL;
      duty_cycle_stabilizer <= acrm_pkg::R_CLOCK[acrm_pkg::P_DUTY_STAB];
      outputs_disabled      <= 1'b0;
      dither_enable         <= 1'b0;
      lvds_output           <= 1'b0;
    end else if (ce) begin
      if (filt_q[acrm_pkg::I_PDN]) begin
        power_mode <= pwr_a_q[acrm_pkg::P_PIN_STBY] ? acrm_pkg::PWR_STANDBY
                                                     : acrm_pkg::PWR_FULL_DOWN;
      end else begin
        case (pwr_a_q[1:0])
          2'h1:    power_mode <= acrm_pkg::PWR_FULL_DOWN;
          2'h2:    power_mode <= acrm_pkg::PWR_STANDBY;
          default: power_mode <= acrm_pkg::PWR_NORMAL;
        endcase
      end
      duty_cycle_stabilizer <= clk_a_q[acrm_pkg::P_DUTY_STAB];
      outputs_disabled <= om_a_q[acrm_pkg::P_OM_OFF] | filt_q[acrm_pkg::I_OE];
      dither_enable    <= dth_m_q[acrm_pkg::P_DITH_EN] | filt_q[acrm_pkg::I_DITH];
      lvds_output      <= om_a_q[acrm_pkg::P_OM_TYPE] | filt_q[acrm_pkg::I_TYPE];
    end
  end

  // ------------------------------------------------------------
  // Pattern generators
  // ------------------------------------------------------------
  assign built_in_self_test_start   = st_a_q[acrm_pkg::P_ST_EN] & ~built_in_self_test_active;
  assign built_in_self_test_restart = built_in_self_test_start & st_a_q[acrm_pkg::P_ST_RESTART];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      long_seq_q  <= acrm_pkg::SEED_LONG;
      short_seq_q <= acrm_pkg::SEED_SHORT;
      alt_q       <= 1'b0;
    end else if (ce) begin
      if (tst_a_q[acrm_pkg::P_RST_LONG] || built_in_self_test_restart) begin
        long_seq_q <= acrm_pkg::SEED_LONG;
      end else begin
        long_seq_q <= {long_seq_q[21:0], long_seq_q[22] ^ long_seq_q[17]};
      end
      if (tst_a_q[acrm_pkg::P_RST_SHORT]) begin
        short_seq_q <= acrm_pkg::SEED_SHORT;
      end else begin
        short_seq_q <= {short_seq_q[7:0], short_seq_q[8] ^ short_seq_q[4]};
      end
      alt_q <= ~alt_q;
    end
  end

  // ------------------------------------------------------------
  // Output data selection
  // ------------------------------------------------------------
  assign test_mode = acrm_pkg::acrm_test_t'(tst_a_q[2:0]);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_out <= 14'h0000;
    end else if (ce) begin
      if (built_in_self_test_active) begin
        data_out <= long_seq_q[13:0];
      end else begin
        case (test_mode)
          acrm_pkg::TST_MID:      data_out <= acrm_pkg::PAT_MID;
          acrm_pkg::TST_POS_FULL: data_out <= acrm_pkg::PAT_POS;
          acrm_pkg::TST_NEG_FULL: data_out <= acrm_pkg::PAT_NEG;
          acrm_pkg::TST_CHECKER:  data_out <= alt_q ? acrm_pkg::PAT_CHK_B
                                                    : acrm_pkg::PAT_CHK_A;
          acrm_pkg::TST_LONG_PN:  data_out <= long_seq_q[13:0];
          acrm_pkg::TST_SHORT_PN: data_out <= {short_seq_q, short_seq_q[8:4]};
          acrm_pkg::TST_ONE_ZERO: data_out <= alt_q ? acrm_pkg::PAT_NEG
                                                    : acrm_pkg::PAT_POS;
          default:                data_out <= adc_data;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Self test signature
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      built_in_self_test_active    <= 1'b0;
      built_in_self_test_signature <= 16'h0000;
    end else if (ce) begin
      built_in_self_test_active <= st_a_q[acrm_pkg::P_ST_EN];
      if (built_in_self_test_restart) begin
        built_in_self_test_signature <= 16'h0000;
      end else if (built_in_self_test_active) begin
        built_in_self_test_signature <= {built_in_self_test_signature[14:0],
                           built_in_self_test_signature[15] ^ built_in_self_test_signature[14]
                           ^ built_in_self_test_signature[12] ^ built_in_self_test_signature[3]}
                          ^ {2'h0, data_out};
      end
    end
  end

  // ------------------------------------------------------------
  // Readback view published to the link side
  // ------------------------------------------------------------
  always_comb begin
    live = '0;
    live.setup  = acrm_pkg::R_SETUP | ({8{lsb_q}} & acrm_pkg::M_LSB);
    live.id     = PART_IDENTIFIER;
    live.grade  = {2'h0, SPEED_GRADE, 4'h0};
    live.power  = pwr_m_q;
    live.clock  = clk_m_q;
    live.test   = tst_m_q;
    live.stest  = st_m_q;
    live.omode  = om_m_q;
    live.dither = dth_m_q;
    live.commit = {7'h00, xfer_q};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      view_q     <= '0;
      view_tog_q <= 1'b0;
    end else if (ce && live != view_q) begin
      view_q     <= live;
      view_tog_q <= ~view_tog_q;
    end
  end
endmodule
`default_nettype wire

// file: tb/acrm_props.sv
// Port assertions for the converter configuration bank
`timescale 1ns/1ns
`default_nettype none
module acrm_props (
  // Core clock and link select
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  csb_n,
  input wire logic                  sdio_oe,
  // Pins and effective controls
  input wire logic                  power_down_pin,
  input wire logic                  output_enable_pin,
  input wire logic                  dither_pin,
  input wire logic                  output_type_pin,
  input wire acrm_pkg::acrm_power_t power_mode,
  input wire logic                  outputs_disabled,
  input wire logic                  dither_enable,
  input wire logic                  lvds_output,
  input wire logic                  built_in_self_test_active
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_pdn;
    power_down_pin [*8] |=> power_mode != acrm_pkg::PWR_NORMAL;
  endproperty
  a_pdn: assert property (p_pdn) else $error("pin power-down lost");
  property p_oen;
    output_enable_pin [*8] |=> outputs_disabled;
  endproperty
  a_oen: assert property (p_oen) else $error("pin disable lost");
  property p_dth;
    dither_pin [*8] |=> dither_enable;
  endproperty
  a_dth: assert property (p_dth) else $error("pin dither lost");
  property p_typ;
    output_type_pin [*8] |=> lvds_output;
  endproperty
  a_typ: assert property (p_typ) else $error("pin output type lost");
  property p_mode;
    2'(power_mode) != 2'h3;
  endproperty
  a_mode: assert property (p_mode) else $error("bad power mode");
  property p_idle;
    csb_n |-> !sdio_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("drive while deselected");
  property p_late;
    $fell(csb_n) |-> !sdio_oe [*8];
  endproperty
  a_late: assert property (p_late) else $error("drive during instruction");
  property p_len;
    $rose(sdio_oe) |-> sdio_oe [*8];
  endproperty
  a_len: assert property (p_len) else $error("read drive too short");
  c_stby: cover property (power_mode == acrm_pkg::PWR_STANDBY);
  c_built_in_self_test: cover property ($rose(built_in_self_test_active));
  c_read: cover property ($rose(sdio_oe));
endmodule
bind acrm_register_bank acrm_props u_props (.*);
`default_nettype wire

// file: tb/acrm_host.sv
// Serial host that frames configuration reads and writes
`timescale 1ns/1ns
`default_nettype none
module acrm_host (
  // Link pins
  output var  logic sclk,
  output var  logic csb_n,
  output var  logic sdio_in,
  input  wire logic sdio_out
);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_in = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
                      input logic lsb, output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 2'b00, a, d};
    q = 8'h00;
    #1;
    csb_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (rd && i > 15) sdio_in = ~sdio_in;
      else sdio_in = lsb ? w[i < 16 ? i + 8 : i - 16] : w[23 - i];
      #6;
      if (i > 15) q[lsb ? i - 16 : 23 - i] = sdio_out;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #6;
    csb_n = 1'b1;
    #12;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_adc_config_register_map.sv
// Self-checking bench for the converter configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_adc_config_register_map;
  // Arbitrary part code
  localparam logic [7:0] ID = 8'h5A;
  logic                  clock, rst_n, sclk, csb_n, sdio_in, sdio_out, sdio_oe;
  logic                  power_down_pin, output_enable_pin, dither_pin, output_type_pin;
  logic                  outputs_disabled, dither_enable, lvds_output, built_in_self_test_active;
  logic                  duty_cycle_stabilizer;
  logic [15:0]           built_in_self_test_signature;
  logic [13:0]           adc_data, data_out, x;
  logic [7:0]            q;
  acrm_pkg::acrm_power_t power_mode, e;
  int                    n_errors, n_tests, i;
  logic [12:0] ra [9] = '{13'h0, 13'h1, 13'h2, 13'h8, 13'h9, 13'hD, 13'hE, 13'hFF, 13'h13};
  logic [7:0]  rv [9] = '{8'h18, ID, 8'h20, 8'h80, 8'h01, 8'h00, 8'h04, 8'h00, 8'h00};
  logic [7:0]  tw [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h35, 8'h36, 8'h07};
  logic [13:0] ta [8] = '{14'h1234, 14'h2000, 14'h3FFF, 14'h0, 14'h2AAA, 14'h3FFF, 14'h3FFF,
                          14'h3FFF};
  logic [13:0] tb [8] = '{14'h1234, 14'h2000, 14'h3FFF, 14'h0, 14'h1555, 14'h3FFF, 14'h3FFF,
                          14'h0};
  acrm_register_bank #(.PART_IDENTIFIER(ID), .SPEED_GRADE(2'h2)) DUT (
    .clock, .rst_n, .ce(1'b1), .sclk, .csb_n, .sdio_in, .sdio_out, .sdio_oe,
    .power_down_pin, .output_enable_pin, .dither_pin, .output_type_pin, .adc_data,
    .data_out, .power_mode, .duty_cycle_stabilizer, .outputs_disabled, .dither_enable,
    .lvds_output, .built_in_self_test_active, .built_in_self_test_signature);
  acrm_host u_host (.sclk, .csb_n, .sdio_in, .sdio_out);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l = 1'b0);
    u_host.xfer(1'b0, a, d, l, q);
    cyc(12);
  endtask
  task automatic rchk(input logic [12:0] a, input logic [7:0] v, input logic l = 1'b0);
    u_host.xfer(1'b1, a, 8'h00, l, q);
    chk(q, v);
  endtask
  task automatic print_verdict;
    $display("Errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    cyc(40000);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    {power_down_pin, output_enable_pin, dither_pin, output_type_pin} = 4'h0;
    adc_data = 14'h1234;
    cyc(16);
    @(posedge clock) rst_n <= 1'b1;
    cyc(12);
    for (i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    wr(13'h1, 8'hFF);
    rchk(13'h1, ID);
    e = acrm_pkg::PWR_NORMAL;
    for (i = 0; i < 4; i++) begin
      wr(13'h8, 8'(i));
      chk(power_mode, e);
      wr(13'hFF, 8'h01);
      e = i[0] ^ i[1] ? acrm_pkg::acrm_power_t'(i) : acrm_pkg::PWR_NORMAL;
      chk(power_mode, e);
    end
    rchk(13'hFF, 8'h00);
    rchk(13'h8, 8'h83);
    for (i = 0; i < 8; i++) begin
      wr(13'hD, tw[i]);
      wr(13'hFF, 8'h01);
      x = data_out;
      cyc(1);
      chk((x === ta[i] && data_out === tb[i]) || (x === tb[i] && data_out === ta[i]), 1);
    end
    wr(13'hD, 8'h00);
    wr(13'h0, 8'h42);
    rchk(13'h0, 8'h5A, 1'b1);
    wr(13'h0, 8'h24, 1'b1);
    rchk(13'h0, 8'h18);
    rchk(13'h8, 8'h80);
    @(posedge clock) {power_down_pin, output_enable_pin, dither_pin, output_type_pin} <= 4'hF;
    cyc(10);
    chk({power_mode, outputs_disabled, dither_enable, lvds_output}, 5'h0F);
    wr(13'h8, 8'h20);
    wr(13'hFF, 8'h01);
    chk({power_mode, outputs_disabled, dither_enable, lvds_output}, 5'h17);
    @(posedge clock) {power_down_pin, output_enable_pin, dither_pin, output_type_pin} <= 4'h0;
    cyc(10);
    chk({power_mode, outputs_disabled, dither_enable, lvds_output}, 5'h00);
    wr(13'h9, 8'h00);
    wr(13'h14, 8'h50);
    wr(13'h30, 8'h10);
    chk({outputs_disabled, dither_enable, lvds_output, duty_cycle_stabilizer}, 4'h5);
    wr(13'hFF, 8'h01);
    chk({outputs_disabled, dither_enable, lvds_output, duty_cycle_stabilizer}, 4'hE);
    chk(built_in_self_test_signature, 16'h0000);
    wr(13'hE, 8'h05);
    wr(13'hFF, 8'h01);
    chk(built_in_self_test_active, 1'b1);
    rchk(13'hE, 8'h05);
    chk(built_in_self_test_signature != 16'h0000, 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
